// File: hdl/eeb_pkg.sv
// Shared constants and types for the two-wire serial memory slave.
// Assumes a 100 MHz system clock; all users reference names as eeb_pkg::name.

package eeb_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WR_TIME_MS = 10;
  // Longest time, rounded down to whole cycles
  localparam int unsigned WR_CYCLES = WR_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Protocol fields
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam int unsigned PAGE_AW = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned SEL_PINS = 3;
  localparam int unsigned TINY_BYTES = 128;

  // ----------------------------------------------------------------
  // Pin sampler layout {wp, sel2, sel1, sel0, sda, scl}
  // ----------------------------------------------------------------
  localparam int unsigned PIN_N = 6;
  localparam int unsigned PIN_SCL = 0;
  localparam int unsigned PIN_SDA = 1;
  localparam int unsigned PIN_SEL0 = 2;
  localparam int unsigned PIN_WP = 5;
  localparam logic [5:0] PIN_RST = 6'h03;

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DEV   = 3'h1,
    ST_WADDR = 3'h2,
    ST_WDATA = 3'h3,
    ST_ACK   = 3'h4,
    ST_RDATA = 3'h5,
    ST_RACK  = 3'h6
  } eeb_state_t;

endpackage

// File: hdl/eeb_serial_eeprom_bus_slave.sv
// Two-wire serial memory slave: protocol engine, page buffer, array, write timer.
// Assumes an external pull-up on the data wire and a master that owns the clock wire.
//
// Function
// - START is data falling while clock high
// - STOP is data rising; ends transaction
// - Data changes only while clock low
// - Slave address top nibble must be 1010
// - Select bits must match select pins
// - Larger densities reuse select bits as address
// - Floating select pins read as zero
// - Address LSB: 1 read, 0 write
// - Receiver acknowledges on ninth clock pulse
// - Acknowledge address and every written byte
// - Read: send byte, sample master acknowledge
// - Byte write: address, pointer, data, STOP
// - STOP after write starts programming; ignore bus
// - Programming lasts 10 ms, data released
// - Page write takes up to 16 bytes
// - Page write wraps low four address bits
// - No acknowledge while programming is busy
// - Write protect refuses first data byte
// - Counter holds last address plus one
// - Counter wraps, except smallest density saturates
// - Selective read via dummy write then restart
// - Sequential read increments across all bits

`timescale 1ns/100ps

module eeb_serial_eeprom_bus_slave #(
  parameter int unsigned MEM_BYTES = 2048,
  parameter int unsigned PROG_CYCLES = eeb_pkg::WR_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin_0,
  input wire logic address_select_pin_1,
  input wire logic address_select_pin_2,
  input wire logic write_protect,
  output logic prog_busy
);

  localparam int unsigned AW = $clog2(MEM_BYTES);
  localparam int unsigned HI_BITS = (AW > 8) ? AW - 8 : 0;
  localparam int unsigned PCW = $clog2(PROG_CYCLES + 1);
  localparam int unsigned PW = eeb_pkg::PAGE_AW;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // Only a data bit lives here; it is held stable for a whole clock
  // period, so the system side may read it once the rise is seen.
  logic link_bit_q;

  always_ff @(posedge scl_clk) begin
    link_bit_q <= sda_in;
  end

  logic bit_s1_q;
  logic bit_s2_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bit_s1_q <= 1'b1;
      bit_s2_q <= 1'b1;
    end else begin
      bit_s1_q <= link_bit_q;
      bit_s2_q <= bit_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [eeb_pkg::PIN_N-1:0] pin_raw;
  logic [eeb_pkg::PIN_N-1:0] p1_q;
  logic [eeb_pkg::PIN_N-1:0] p2_q;
  logic [eeb_pkg::PIN_N-1:0] p3_q;
  logic [eeb_pkg::PIN_N-1:0] pf_q;

  assign pin_raw = {write_protect, address_select_pin_2, address_select_pin_1,
                    address_select_pin_0, sda_in, scl_clk};

  generate
    for (genvar gi = 0; gi < eeb_pkg::PIN_N; gi++) begin : g_pin
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          p1_q[gi] <= eeb_pkg::PIN_RST[gi];
          p2_q[gi] <= eeb_pkg::PIN_RST[gi];
          p3_q[gi] <= eeb_pkg::PIN_RST[gi];
          pf_q[gi] <= eeb_pkg::PIN_RST[gi];
        end else begin
          p1_q[gi] <= pin_raw[gi];
          p2_q[gi] <= p1_q[gi];
          p3_q[gi] <= p2_q[gi];
          // Glitch shorter than a cycle never reaches the engine
          if (p2_q[gi] == p3_q[gi]) begin
            pf_q[gi] <= p3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic [eeb_pkg::SEL_PINS-1:0] sel_f;

  assign scl_f = pf_q[eeb_pkg::PIN_SCL];
  assign sda_f = pf_q[eeb_pkg::PIN_SDA];
  assign wp_f = pf_q[eeb_pkg::PIN_WP];
  assign sel_f = pf_q[eeb_pkg::PIN_SEL0 +: eeb_pkg::SEL_PINS];

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic scl_prev_q;
  logic sda_prev_q;
  logic bit_ev_q;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bit_ev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
      // One cycle late so the crossed data bit has settled
      bit_ev_q <= scl_f & ~scl_prev_q;
    end
  end

  assign fall_ev = ~scl_f & scl_prev_q;
  assign start_ev = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_ev = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // ----------------------------------------------------------------
  // Engine state and decode
  // ----------------------------------------------------------------
  eeb_pkg::eeb_state_t state_q;
  eeb_pkg::eeb_state_t nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic ack_q;
  logic ackdrv_q;
  logic [2:0] dev_hi_q;
  logic [AW-1:0] ptr_q;
  logic [eeb_pkg::PAGE_BYTES-1:0] valid_q;
  logic wr_pend_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic busy_q;
  logic [PCW-1:0] prog_cnt_q;
  logic [AW-PW-1:0] prog_page_q;

  logic [7:0] mem [0:MEM_BYTES-1];
  logic [7:0] page_buf [0:eeb_pkg::PAGE_BYTES-1];

  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic [10:0] full_addr;
  logic [AW-1:0] ptr_rd_nxt;
  logic [AW-1:0] ptr_pg_nxt;
  logic sel_ok;
  logic dev_match;
  logic evt_ok;
  logic buf_we;
  logic mem_we;

  assign rx_byte = {shift_q[6:0], bit_s2_q};
  assign rd_byte = mem[ptr_q];
  assign full_addr = {dev_hi_q, rx_byte};
  assign evt_ok = ~busy_q & ~stop_ev & ~start_ev;

  always_comb begin
    sel_ok = 1'b1;
    for (int i = 0; i < eeb_pkg::SEL_PINS; i++) begin
      // Unused pins are skipped; floating ones arrive pulled to zero
      if (i >= HI_BITS && rx_byte[i+1] != sel_f[i]) begin
        sel_ok = 1'b0;
      end
    end
  end

  assign dev_match = (rx_byte[7:4] == eeb_pkg::DEV_TYPE) & sel_ok;

  // Smallest part holds at its top address instead of wrapping
  always_comb begin
    if (MEM_BYTES == eeb_pkg::TINY_BYTES && ptr_q == '1) begin
      ptr_rd_nxt = ptr_q;
    end else begin
      ptr_rd_nxt = ptr_q + 1'b1;
    end
  end

  assign ptr_pg_nxt = {ptr_q[AW-1:PW], ptr_q[PW-1:0] + 4'h1};

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= eeb_pkg::ST_IDLE;
      nxt_q <= eeb_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      ackdrv_q <= 1'b0;
      dev_hi_q <= 3'h0;
      ptr_q <= '0;
      valid_q <= '0;
      wr_pend_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (busy_q) begin
      // Deaf and released until programming is done
      state_q <= eeb_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= eeb_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (start_ev) begin
      // Restart abandons any unfinished write
      state_q <= eeb_pkg::ST_DEV;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      case (state_q)
        eeb_pkg::ST_DEV, eeb_pkg::ST_WADDR, eeb_pkg::ST_WDATA: begin
          if (bit_ev_q) begin
            shift_q <= rx_byte;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == eeb_pkg::CNT_LAST) begin
              cnt_q <= 4'h0;
              ackdrv_q <= 1'b0;
              state_q <= eeb_pkg::ST_ACK;
              case (state_q)
                eeb_pkg::ST_DEV: begin
                  ack_q <= dev_match;
                  dev_hi_q <= rx_byte[3:1];
                  if (rx_byte[0]) begin
                    nxt_q <= eeb_pkg::ST_RDATA;
                  end else begin
                    nxt_q <= eeb_pkg::ST_WADDR;
                  end
                end
                eeb_pkg::ST_WADDR: begin
                  ack_q <= 1'b1;
                  ptr_q <= full_addr[AW-1:0];
                  valid_q <= '0;
                  nxt_q <= eeb_pkg::ST_WDATA;
                end
                default: begin
                  if (wp_f) begin
                    ack_q <= 1'b0;
                  end else begin
                    ack_q <= 1'b1;
                    wr_pend_q <= 1'b1;
                    valid_q[ptr_q[PW-1:0]] <= 1'b1;
                    ptr_q <= ptr_pg_nxt;
                  end
                  nxt_q <= eeb_pkg::ST_WDATA;
                end
              endcase
            end
          end
        end
        eeb_pkg::ST_ACK: begin
          if (fall_ev) begin
            if (!ackdrv_q) begin
              // Start of the ninth pulse
              sda_oe_q <= ack_q;
              ackdrv_q <= 1'b1;
              if (!ack_q) begin
                state_q <= eeb_pkg::ST_IDLE;
              end
            end else if (nxt_q == eeb_pkg::ST_RDATA) begin
              sda_oe_q <= ~rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
              ptr_q <= ptr_rd_nxt;
              cnt_q <= 4'h0;
              state_q <= eeb_pkg::ST_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              cnt_q <= 4'h0;
              state_q <= nxt_q;
            end
          end
        end
        eeb_pkg::ST_RDATA: begin
          if (bit_ev_q) begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (fall_ev) begin
            if (cnt_q == eeb_pkg::CNT_BYTE) begin
              sda_oe_q <= 1'b0;
              ack_q <= 1'b0;
              state_q <= eeb_pkg::ST_RACK;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        eeb_pkg::ST_RACK: begin
          if (bit_ev_q) begin
            if (!bit_s2_q) begin
              ack_q <= 1'b1;
            end else begin
              state_q <= eeb_pkg::ST_IDLE;
            end
          end
          if (fall_ev && ack_q) begin
            sda_oe_q <= ~rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b0};
            ptr_q <= ptr_rd_nxt;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            state_q <= eeb_pkg::ST_RDATA;
          end
        end
        default: begin
          state_q <= eeb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  assign buf_we = evt_ok & (state_q == eeb_pkg::ST_WDATA) & bit_ev_q &
                  (cnt_q == eeb_pkg::CNT_LAST) & ~wp_f;

  always_ff @(posedge clock) begin
    if (buf_we) begin
      page_buf[ptr_q[PW-1:0]] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Programming cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      prog_cnt_q <= '0;
      prog_page_q <= '0;
    end else if (busy_q) begin
      prog_cnt_q <= prog_cnt_q + 1'b1;
      if (prog_cnt_q == PCW'(PROG_CYCLES - 1)) begin
        busy_q <= 1'b0;
      end
    end else if (stop_ev && wr_pend_q) begin
      busy_q <= 1'b1;
      prog_cnt_q <= '0;
      prog_page_q <= ptr_q[AW-1:PW];
    end
  end

  // Every buffered byte of the page lands in the first sixteen cycles of the busy time;
  // the remainder only models the slow cell write.
  assign mem_we = busy_q & (prog_cnt_q < PCW'(eeb_pkg::PAGE_BYTES)) &
                  valid_q[prog_cnt_q[PW-1:0]];

  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[{prog_page_q, prog_cnt_q[PW-1:0]}] <= page_buf[prog_cnt_q[PW-1:0]];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: the level driven is always low, only the enable moves
  always_ff @(posedge clock) begin
    sda_out_q <= 1'b0;
  end

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign prog_busy = busy_q;

endmodule

// File: verification/eeb_master.sv
// Two-wire master model: owns the clock wire, pulls the data wire low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module eeb_master (
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda
);
  logic tick;
  // ----
  // Link time base, 15 ns
  // ----
  // Clock wire stands still between frames
  initial begin
    tick = 1'b0;
    scl_clk = 1'b1;
    sda_pull = 1'b0;
    forever #7.5 tick = ~tick;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge tick);
  endtask
  task automatic start();
    hold(4);
    sda_pull = 1'b0;
    hold(4);
    scl_clk = 1'b1;
    hold(8);
    sda_pull = 1'b1;
    hold(8);
    scl_clk = 1'b0;
  endtask
  task automatic stop();
    hold(4);
    sda_pull = 1'b1;
    hold(4);
    scl_clk = 1'b1;
    hold(8);
    sda_pull = 1'b0;
    hold(16);
  endtask
  // Mid-low data change keeps clear of the slave's own turnaround
  task automatic bit_io(input logic b, output logic r);
    hold(4);
    sda_pull = ~b;
    hold(4);
    scl_clk = 1'b1;
    hold(4);
    r = sda;
    hold(4);
    scl_clk = 1'b0;
  endtask
  // Last bit 1 releases for slave ack, or is a master nack
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, r);
    ack = ~r;
  endtask
endmodule

// File: verification/eeb_slave_properties.sv
// Concurrent checks on the slave's pins, attached by bind.
// Assumes each clock-wire phase lasts at least ten system clocks.
`timescale 1ns/100ps
module eeb_slave_properties #(
  parameter int unsigned PROG_CYCLES = eeb_pkg::WR_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic address_select_pin_0,
  input wire logic address_select_pin_1,
  input wire logic address_select_pin_2,
  input wire logic write_protect,
  input wire logic prog_busy
);
  logic [19:0] busy_cnt_q;
  // ----
  // Busy length counter
  // ----
  always_ff @(posedge clock) begin
    if (sys_rst || !prog_busy) begin
      busy_cnt_q <= 20'h00000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 20'h00001;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data wire driven high");
  busy_quiet_a: assert property (prog_busy |-> !sda_oe)
    else $error("drive while busy");
  busy_len_a: assert property ($fell(prog_busy) |-> busy_cnt_q == 20'(PROG_CYCLES))
    else $error("busy length off");
  low_phase_a: assert property ($changed(sda_oe) |-> !scl_clk && !$past(scl_clk, 3))
    else $error("drive change in high phase");
  stop_starts_a: assert property ($rose(prog_busy) |-> scl_clk && sda_in)
    else $error("busy without stop");
  protect_no_prog_a: assert property ($rose(prog_busy) |-> !write_protect)
    else $error("program while protected");
  ack_stands_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("drive too short");
  start_quiet_a: assert property (scl_clk && $fell(sda_in) && !sda_oe |=> !sda_oe [*8])
    else $error("drive right after start");
endmodule
bind eeb_serial_eeprom_bus_slave eeb_slave_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clock(clock),
  .sys_rst(sys_rst),
  .scl_clk(scl_clk),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .address_select_pin_0(address_select_pin_0),
  .address_select_pin_1(address_select_pin_1),
  .address_select_pin_2(address_select_pin_2),
  .write_protect(write_protect),
  .prog_busy(prog_busy)
);

// File: verification/eeb_serial_eeprom_bus_slave_tb.sv
// Self-checking bench: select, write, polling, page wrap, reads, protect.
// Assumes the master model and a 256-byte part strapped to 101.
`timescale 1ns/100ps
module eeb_serial_eeprom_bus_slave_tb;
  localparam int unsigned PROG = 1000;
  localparam logic [7:0] DW = 8'haa;
  localparam logic [7:0] DR = 8'hab;
  logic clock, sys_rst, sda_in, sda_out, sda_oe, write_protect, prog_busy, scl_clk, sda_pull;
  logic [2:0] sel;
  logic [7:0] q;
  logic [7:0] e [16];
  logic a;
  int errors;
  int n_compared;
  // Open-drain wire with pull-up
  assign sda_in = ~((sda_oe & ~sda_out) | sda_pull);
  eeb_serial_eeprom_bus_slave #(.MEM_BYTES(256), .PROG_CYCLES(PROG)) dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_clk(scl_clk),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .address_select_pin_0(sel[0]),
    .address_select_pin_1(sel[1]),
    .address_select_pin_2(sel[2]),
    .write_protect(write_protect),
    .prog_busy(prog_busy)
  );
  eeb_master m (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda(sda_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----
  // Shared steps
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic ea);
    m.byte_io(d, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, ea});
  endtask
  task automatic rd(input logic nack, input logic [7:0] exp);
    m.byte_io(8'hff, nack, q, a);
    chk(q, exp);
  endtask
  task automatic wait_prog();
    chk({7'h00, prog_busy}, 8'h01);
    for (int i = 0; i < 1200 && prog_busy; i++)
      @(posedge clock);
    @(negedge clock);
    chk({7'h00, prog_busy}, 8'h00);
  endtask
  task automatic wr1(input logic [7:0] ad, input logic [7:0] d);
    m.start();
    send(DW, 1'b1);
    send(ad, 1'b1);
    send(d, 1'b1);
    m.stop();
    wait_prog();
  endtask
  // Leaves the slave about to send the addressed byte
  task automatic sr(input logic [7:0] ad);
    m.start();
    send(DW, 1'b1);
    send(ad, 1'b1);
    m.start();
    send(DR, 1'b1);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_select();
    m.start();
    send(8'h9a, 1'b0);
    m.start();
    send(8'hac, 1'b0);
    m.stop();
  endtask
  task automatic t_byte();
    m.start();
    send(DW, 1'b1);
    send(8'h10, 1'b1);
    send(8'h5c, 1'b1);
    m.stop();
    m.start();
    send(DW, 1'b0);
    m.stop();
    wait_prog();
    m.start();
    send(DW, 1'b1);
    m.stop();
    sr(8'h10);
    rd(1'b1, 8'h5c);
    // Give a slave that wrongly keeps sending time to drive
    repeat (10) @(negedge clock);
    chk({7'h00, sda_oe}, 8'h00);
    m.stop();
  endtask
  task automatic t_page();
    m.start();
    send(DW, 1'b1);
    send(8'h2e, 1'b1);
    for (int i = 0; i < 18; i++) begin
      send(8'h40 + 8'(i), 1'b1);
      e[(14 + i) % 16] = 8'h40 + 8'(i);
    end
    m.stop();
    wait_prog();
    sr(8'h20);
    for (int j = 0; j < 15; j++) begin
      rd(j == 14, e[j]);
    end
    m.stop();
    m.start();
    send(DR, 1'b1);
    rd(1'b1, e[15]);
    m.stop();
  endtask
  task automatic t_wrap();
    wr1(8'hff, 8'h77);
    wr1(8'h00, 8'h33);
    sr(8'hff);
    rd(1'b0, 8'h77);
    rd(1'b1, 8'h33);
    m.stop();
  endtask
  task automatic t_protect();
    wr1(8'h40, 8'h11);
    @(negedge clock);
    write_protect = 1'b1;
    m.start();
    send(DW, 1'b1);
    send(8'h40, 1'b1);
    send(8'h99, 1'b0);
    m.stop();
    chk({7'h00, prog_busy}, 8'h00);
    @(negedge clock);
    write_protect = 1'b0;
    sr(8'h40);
    rd(1'b1, 8'h11);
    m.stop();
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Roughly twice the expected run length
  initial begin
    #400_000;
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    write_protect = 1'b0;
    sel = 3'h5;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (10) @(negedge clock);
    t_select();
    t_byte();
    t_page();
    t_wrap();
    t_protect();
    wrap_up();
  end
endmodule
